// >>> hdl/wfs_pkg.sv
// Functional notes
// [RL1] Valid-rate mode: wake on sync within timeout
// [RL2] Criterion select: pattern, random, equal, sync
// [RL3] Wake pattern: low byte chips 7..0
// [RL4] Chip limit 7 bits, max 127 chips
// [RL5] Zero limit: random/equal wake at sync
// [RL6] Pattern mode: zero never wakes, fill first
// [RL7] Four marker modes: single, parallel, gap, extended
// [RL8] Every marker setting exists for A and B
// [RL9] Search from sync or wake, until match/loss
// [RL10] Two 16-chip correlators with own length, pattern
// [RL11] Software sets A length 16 when B used
// [RL12] Parallel: first match raises frame sync
// [RL13] Gap mode: A, gap, then B
// [RL14] Extended: insert 0 for A, 1 for B
// [RL15] Markers must differ from wake stream, run-in
// [RL16] Wake search aborts on sync loss, limit ends
// [RL17] Three equal chips flag a code violation
// [RL18] Correlator length 0 to 16 chips
// [RL19] One-cycle wake and frame sync pulses
// [RL20] Compare latest active-length chips to reference
package wfs_pkg;
  // Printed offsets (register index); byte address is four times the index
  localparam logic [7:0] WFS_IDX_WAKE_CTRL_A = 8'h25;
  localparam logic [7:0] WFS_IDX_WAKE_PAT_LO_A = 8'h26;
  localparam logic [7:0] WFS_IDX_WAKE_PAT_HI_A = 8'h27;
  localparam logic [7:0] WFS_IDX_WAKE_CNT_A = 8'h28;
  localparam logic [7:0] WFS_IDX_WAKE_CTRL_B = 8'h46;
  localparam logic [7:0] WFS_IDX_WAKE_PAT_LO_B = 8'h47;
  localparam logic [7:0] WFS_IDX_WAKE_PAT_HI_B = 8'h48;
  localparam logic [7:0] WFS_IDX_WAKE_CNT_B = 8'h49;
  // Marker registers, config A base; config B adds the set offset
  localparam logic [7:0] WFS_IDX_MARK_MODE = 8'h82;
  localparam logic [7:0] WFS_IDX_CORR_A_LEN = 8'h83;
  localparam logic [7:0] WFS_IDX_CORR_B_LEN = 8'h84;
  localparam logic [7:0] WFS_IDX_CORR_A_LO = 8'h86;
  localparam logic [7:0] WFS_IDX_CORR_A_HI = 8'h87;
  localparam logic [7:0] WFS_IDX_CORR_B_LO = 8'h88;
  localparam logic [7:0] WFS_IDX_CORR_B_HI = 8'h89;
  localparam logic [7:0] WFS_IDX_SET_B_OFS = 8'h20;
  // Own registers
  localparam logic [7:0] WFS_IDX_MARK_GAP_A = 8'h8b;
  localparam logic [7:0] WFS_IDX_GLOBAL_CTRL = 8'hc0;
  localparam logic [7:0] WFS_IDX_STATUS = 8'hc1;
  localparam logic [7:0] WFS_IDX_TIMEOUT = 8'hc2;
  localparam logic [7:0] WFS_RESET_BYTE = 8'h00;
  // Fields
  localparam int WFS_CRIT_LSB = 0;
  localparam int WFS_CNT_W = 7;
  localparam int WFS_LEN_W = 5;
  localparam logic [4:0] WFS_LEN_MAX = 5'h10;
  localparam logic [6:0] WFS_FILL_CHIPS = 7'h10;
  localparam int WFS_CTRL_SET_BIT = 0;
  localparam int WFS_CTRL_POLL_BIT = 1;
  // Sync search timeout: 7.625 data bits = 61 half-chip quarters; in chips
  localparam logic [7:0] WFS_TIMEOUT_RESET = 8'h0f;
  typedef enum logic [1:0] {
    WFS_CRIT_PATTERN = 2'b00,
    WFS_CRIT_RANDOM = 2'b01,
    WFS_CRIT_EQUAL = 2'b10,
    WFS_CRIT_SYNC = 2'b11
  } wfs_crit_t;
  typedef enum logic [1:0] {
    WFS_MODE_SINGLE = 2'b00,
    WFS_MODE_PARALLEL = 2'b01,
    WFS_MODE_GAP = 2'b10,
    WFS_MODE_EXTENDED = 2'b11
  } wfs_mode_t;
  typedef enum logic [2:0] {
    WFS_ST_IDLE = 3'b000,
    WFS_ST_WAKE = 3'b001,
    WFS_ST_SEARCH = 3'b011,
    WFS_ST_GAP = 3'b010,
    WFS_ST_SEARCH_B = 3'b110,
    WFS_ST_FRAMED = 3'b111
  } wfs_state_t;
endpackage : wfs_pkg

// >>> hdl/wfs_top.sv
`timescale 1ns/1ps
module wfs_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Chip stream from clock recovery
  input wire logic chip_data,
  input wire logic chip_strobe,
  input wire logic symbol_sync,
  // Events and payload marker
  output logic wake_pulse,
  output logic frame_sync_pulse,
  output logic ext_bit_valid,
  output logic ext_bit,
  output logic searching
);
  import wfs_pkg::*;

  // ********************************
  // Register file
  // ********************************
  logic [7:0] regs_q [0:255];
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [7:0] rd_idx;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_idx_q <= haddr[9:2];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_reg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          regs_q[gi] <= (gi == WFS_IDX_TIMEOUT) ? WFS_TIMEOUT_RESET : WFS_RESET_BYTE;
        end else if (wr_pend_q && wr_idx_q == 8'(gi)) begin
          regs_q[gi] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  logic [7:0] status_byte;
  logic [31:0] rdata_q;
  assign rd_idx = haddr[9:2];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      rdata_q <= (rd_idx == WFS_IDX_STATUS) ? {24'h00_0000, status_byte} : 32'h0000_0000;
    end
  end
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ********************************
  // Active configuration
  // ********************************
  logic set_b;
  logic self_poll;
  logic [7:0] ob;
  wfs_crit_t crit;
  logic [15:0] wake_ref;
  logic [6:0] wake_chip_limit;
  wfs_mode_t mode;
  logic [4:0] corr_a_length;
  logic [4:0] corr_b_length;
  logic [15:0] corr_a_ref;
  logic [15:0] corr_b_ref;
  logic [7:0] marker_gap_length;
  logic [7:0] timeout_chips;

  assign set_b = regs_q[WFS_IDX_GLOBAL_CTRL][WFS_CTRL_SET_BIT];
  assign self_poll = regs_q[WFS_IDX_GLOBAL_CTRL][WFS_CTRL_POLL_BIT];
  assign ob = set_b ? WFS_IDX_SET_B_OFS : 8'h00;
  assign timeout_chips = regs_q[WFS_IDX_TIMEOUT];
  always_comb begin
    if (set_b) begin // RL8
      crit = wfs_crit_t'(regs_q[WFS_IDX_WAKE_CTRL_B][1:0]); // RL2
      wake_ref = {regs_q[WFS_IDX_WAKE_PAT_HI_B], regs_q[WFS_IDX_WAKE_PAT_LO_B]}; // RL3
      wake_chip_limit = regs_q[WFS_IDX_WAKE_CNT_B][WFS_CNT_W-1:0]; // RL4
    end else begin
      crit = wfs_crit_t'(regs_q[WFS_IDX_WAKE_CTRL_A][1:0]);
      wake_ref = {regs_q[WFS_IDX_WAKE_PAT_HI_A], regs_q[WFS_IDX_WAKE_PAT_LO_A]};
      wake_chip_limit = regs_q[WFS_IDX_WAKE_CNT_A][WFS_CNT_W-1:0];
    end
  end
  assign mode = wfs_mode_t'(regs_q[8'(WFS_IDX_MARK_MODE + ob)][1:0]); // RL7 RL8
  assign corr_a_length = regs_q[8'(WFS_IDX_CORR_A_LEN + ob)][WFS_LEN_W-1:0];
  assign corr_b_length = regs_q[8'(WFS_IDX_CORR_B_LEN + ob)][WFS_LEN_W-1:0];
  assign corr_a_ref = {regs_q[8'(WFS_IDX_CORR_A_HI + ob)], regs_q[8'(WFS_IDX_CORR_A_LO + ob)]};
  assign corr_b_ref = {regs_q[8'(WFS_IDX_CORR_B_HI + ob)], regs_q[8'(WFS_IDX_CORR_B_LO + ob)]};
  assign marker_gap_length = regs_q[8'(WFS_IDX_MARK_GAP_A + ob)];

  // ********************************
  // Chip history and code violation
  // ********************************
  logic [31:0] hist_q;
  logic [6:0] fill_q;
  logic [6:0] fill_d;
  logic code_violation;
  logic [31:0] hist_d;
  assign hist_d = {hist_q[30:0], chip_data};
  // Fewer than three chips since sync cannot hold a violation
  assign code_violation = fill_q >= 7'h02
                          && ((hist_d[2:0] == 3'b000) || (hist_d[2:0] == 3'b111)); // RL17
  assign fill_d = (fill_q == 7'h7f) ? fill_q : 7'(fill_q + 7'h01);

  // ********************************
  // Correlators
  // ********************************
  function automatic logic corr_hit(input logic [15:0] h, input logic [15:0] r,
                                    input logic [4:0] len);
    logic [15:0] m;
    m = (len >= WFS_LEN_MAX) ? 16'hffff : 16'((17'h0_0001 << len) - 17'h0_0001); // RL18
    corr_hit = ((h ^ r) & m) == 16'h0000; // RL20
  endfunction

  logic hit_a;
  logic hit_b;
  logic hit_single;
  assign hit_a = corr_hit(hist_d[15:0], corr_a_ref, corr_a_length) // RL10
                 && (corr_a_length != 5'h00);
  assign hit_b = corr_hit(hist_d[15:0], corr_b_ref, corr_b_length) // RL10
                 && (corr_b_length != 5'h00);
  // Single mode chains B (older chips) in front of A
  assign hit_single = corr_hit(hist_d[15:0], corr_a_ref, corr_a_length)
                      && corr_hit(hist_d[31:16], corr_b_ref, corr_b_length); // RL11

  // ********************************
  // Control
  // ********************************
  wfs_state_t state_q;
  logic [6:0] wcnt_q;
  logic [7:0] gcnt_q;
  logic [7:0] tcnt_q;
  logic sync_q;
  logic timely_q;
  logic wake_d;
  logic frame_sync_pulse_d;
  logic frame_sync_pulse_b;

  always_comb begin
    wake_d = 1'b0;
    frame_sync_pulse_d = 1'b0;
    frame_sync_pulse_b = 1'b0;
    if (symbol_sync) begin
      if (state_q == WFS_ST_WAKE) begin
        unique case (crit)
          WFS_CRIT_SYNC: wake_d = 1'b1; // RL1
          WFS_CRIT_PATTERN: wake_d = chip_strobe && fill_q >= WFS_FILL_CHIPS // RL6
                                     && wcnt_q < wake_chip_limit && hist_d[15:0] == wake_ref;
          default: wake_d = chip_strobe && wcnt_q == wake_chip_limit - 7'h01
                            && !code_violation && wake_chip_limit != 7'h00;
        endcase
        if (crit inside {WFS_CRIT_RANDOM, WFS_CRIT_EQUAL} && wake_chip_limit == 7'h00) begin
          wake_d = 1'b1; // RL5
        end
        // No wake unless sync came within the search timeout
        wake_d = wake_d && timely_q; // RL1 RL16
      end else if (chip_strobe && state_q == WFS_ST_SEARCH) begin
        unique case (mode)
          WFS_MODE_SINGLE: begin
            frame_sync_pulse_d = hit_single;
            frame_sync_pulse_b = 1'b0;
          end
          WFS_MODE_GAP: frame_sync_pulse_d = 1'b0;
          default: begin
            frame_sync_pulse_d = hit_a || hit_b; // RL12
            frame_sync_pulse_b = hit_b && !hit_a;
          end
        endcase
      end else if (chip_strobe && state_q == WFS_ST_SEARCH_B) begin
        frame_sync_pulse_d = hit_b; // RL13
        frame_sync_pulse_b = 1'b1;
      end
    end
  end

  // Window end or a criterion-specific stop closes the wake search
  logic bit_done;
  logic random_stop;
  logic equal_stop;
  logic wake_stop;
  assign bit_done = fill_q[0] && (hist_d[1] != hist_d[0]);
  assign random_stop = crit == WFS_CRIT_RANDOM && code_violation; // RL17
  assign equal_stop = crit == WFS_CRIT_EQUAL && bit_done && fill_q >= 7'h02
                      && hist_d[1] != hist_d[3]; // RL17
  assign wake_stop = wcnt_q >= wake_chip_limit || random_stop || equal_stop; // RL16

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= WFS_ST_IDLE;
    end else if (!symbol_sync) begin
      state_q <= WFS_ST_IDLE; // RL9 RL16
    end else begin
      unique case (state_q)
        WFS_ST_IDLE: state_q <= self_poll ? WFS_ST_WAKE : WFS_ST_SEARCH; // RL9
        WFS_ST_WAKE: begin
          if (wake_d) begin
            state_q <= WFS_ST_SEARCH; // RL9
          end else if (crit == WFS_CRIT_SYNC || (chip_strobe && wake_stop)) begin
            state_q <= WFS_ST_FRAMED; // RL16 end of window, wait for sync loss
          end
        end
        WFS_ST_SEARCH: begin
          if (frame_sync_pulse_d) begin
            state_q <= WFS_ST_FRAMED;
          end else if (chip_strobe && mode == WFS_MODE_GAP && hit_a) begin
            state_q <= WFS_ST_GAP; // RL13
          end
        end
        WFS_ST_GAP: begin
          if (chip_strobe && gcnt_q >= marker_gap_length) begin
            state_q <= WFS_ST_SEARCH_B;
          end
        end
        WFS_ST_SEARCH_B: begin
          if (frame_sync_pulse_d) begin
            state_q <= WFS_ST_FRAMED;
          end
        end
        WFS_ST_FRAMED: state_q <= WFS_ST_FRAMED;
        default: state_q <= WFS_ST_IDLE;
      endcase
    end
  end

  // Chip history, fill and window counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_q <= 32'h0000_0000;
      fill_q <= 7'h00;
      wcnt_q <= 7'h00;
      gcnt_q <= 8'h00;
    end else if (!symbol_sync) begin
      fill_q <= 7'h00;
      wcnt_q <= 7'h00;
      gcnt_q <= 8'h00;
    end else if (chip_strobe) begin
      hist_q <= hist_d;
      fill_q <= fill_d;
      wcnt_q <= (state_q == WFS_ST_WAKE && wcnt_q != 7'h7f) ? 7'(wcnt_q + 7'h01) : wcnt_q; // RL4
      gcnt_q <= (state_q == WFS_ST_GAP) ? 8'(gcnt_q + 8'h01) : 8'h00;
    end
  end

  // Sync search timeout: chips seen without sync, judged once as sync rises
  logic sync_timely;
  assign sync_timely = tcnt_q <= timeout_chips; // RL1 RL16
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt_q <= 8'h00;
      sync_q <= 1'b0;
      timely_q <= 1'b0;
    end else begin
      sync_q <= symbol_sync;
      if (symbol_sync && !sync_q) begin
        timely_q <= sync_timely; // RL1
      end
      if (symbol_sync) begin
        tcnt_q <= 8'h00;
      end else if (chip_strobe && tcnt_q != 8'hff) begin
        tcnt_q <= 8'(tcnt_q + 8'h01);
      end
    end
  end
  // ********************************
  // Outputs
  // ********************************
  logic wake_q;
  logic frame_sync_pulse_q;
  logic ext_v_q;
  logic ext_b_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_q <= 1'b0;
      frame_sync_pulse_q <= 1'b0;
      ext_v_q <= 1'b0;
      ext_b_q <= 1'b0;
    end else begin
      wake_q <= wake_d; // RL19
      frame_sync_pulse_q <= frame_sync_pulse_d; // RL19
      ext_v_q <= frame_sync_pulse_d && mode == WFS_MODE_EXTENDED; // RL14
      ext_b_q <= frame_sync_pulse_d && frame_sync_pulse_b; // RL14
    end
  end
  assign wake_pulse = wake_q;
  assign frame_sync_pulse = frame_sync_pulse_q;
  assign ext_bit_valid = ext_v_q;
  assign ext_bit = ext_b_q;
  assign searching = state_q inside {WFS_ST_SEARCH, WFS_ST_GAP, WFS_ST_SEARCH_B};
  assign status_byte = {4'h0, frame_sync_pulse, state_q};
endmodule : wfs_top

// >>> testbench/wfs_assertions.sv
`timescale 1ns/1ps
// ************
// Event checks
// ************
module wfs_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Stream and events
  input wire logic symbol_sync,
  input wire logic wake_pulse,
  input wire logic frame_sync_pulse,
  input wire logic ext_bit_valid,
  input wire logic ext_bit,
  input wire logic searching
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_wake_pulse;
    wake_pulse |=> !wake_pulse;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse longer than one cycle");
  property p_frame_sync_pulse_pulse;
    frame_sync_pulse |=> !frame_sync_pulse [*3];
  endproperty
  a_frame_sync_pulse_pulse: assert property (p_frame_sync_pulse_pulse)
    else $error("frame sync repeated");
  property p_ext_valid;
    ext_bit_valid |-> frame_sync_pulse;
  endproperty
  a_ext_valid: assert property (p_ext_valid)
    else $error("inserted bit without frame sync");
  property p_loss_idle;
    !symbol_sync |=> !searching;
  endproperty
  a_loss_idle: assert property (p_loss_idle)
    else $error("search kept after sync loss");
  property p_wake_sync;
    wake_pulse |-> $past(symbol_sync);
  endproperty
  a_wake_sync: assert property (p_wake_sync)
    else $error("wake without symbol sync");
  property p_frame_sync_pulse_search;
    frame_sync_pulse |-> $past(searching) && !searching;
  endproperty
  a_frame_sync_pulse_search: assert property (p_frame_sync_pulse_search)
    else $error("frame sync outside search");
  property p_frame_sync_pulse_sync;
    frame_sync_pulse |-> $past(symbol_sync);
  endproperty
  a_frame_sync_pulse_sync: assert property (p_frame_sync_pulse_sync)
    else $error("frame sync without symbol sync");
  property p_framed_hold;
    frame_sync_pulse ##1 symbol_sync [*2] |-> !searching;
  endproperty
  a_framed_hold: assert property (p_framed_hold)
    else $error("search resumed after frame sync");
  c_wake: cover property (wake_pulse);
  c_frame_sync_pulse: cover property (frame_sync_pulse);
  c_ext_b: cover property (ext_bit_valid && ext_bit);
endmodule : wfs_assertions

bind wfs_top wfs_assertions u_wfs_assertions (.hclk, .hresetn, .symbol_sync, .wake_pulse,
  .frame_sync_pulse, .ext_bit_valid, .ext_bit, .searching);

// >>> testbench/wfs_chip_src.sv
`timescale 1ns/1ps
// *****************
// Chip source model
// *****************
module wfs_chip_src (
  // Clock
  input wire logic hclk,
  // Recovered stream
  output logic chip_data,
  output logic chip_strobe,
  output logic symbol_sync
);
  initial begin
    chip_data = 1'b0;
    chip_strobe = 1'b0;
    symbol_sync = 1'b0;
  end
  task automatic set_sync(input logic v);
    symbol_sync <= v;
    @(posedge hclk);
  endtask : set_sync
  // Oldest chip first; between strobes the line shows the inverse chip
  task automatic send(input logic [31:0] p, input int n, input int gap);
    for (int i = n - 1; i >= 0; i--) begin
      chip_data <= p[i];
      chip_strobe <= 1'b1;
      @(posedge hclk);
      if (gap > 1) begin
        chip_strobe <= 1'b0;
        chip_data <= ~p[i];
        repeat (gap - 1) @(posedge hclk);
      end
    end
    if (gap == 1) begin
      chip_strobe <= 1'b0;
    end
  endtask : send
endmodule : wfs_chip_src

// >>> testbench/wfs_top_bench.sv
`timescale 1ns/1ps
module wfs_top_bench;
  import wfs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic chip_data, chip_strobe, symbol_sync, wake_pulse, frame_sync_pulse;
  logic ext_bit_valid, ext_bit, searching, xv, xb;
  int bad_count, comparisons, wk_n, fs_n, cyc;
  assign hready = hreadyout;
  wfs_top u_wfs_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .chip_data, .chip_strobe, .symbol_sync,
    .wake_pulse, .frame_sync_pulse, .ext_bit_valid, .ext_bit, .searching);
  wfs_chip_src u_wfs_chip_src (.hclk, .chip_data, .chip_strobe, .symbol_sync);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ***************************
  // Event monitor and timeout
  // ***************************
  always @(posedge hclk) begin
    cyc++;
    if (wake_pulse === 1'b1) wk_n++;
    if (frame_sync_pulse === 1'b1) begin
      fs_n++;
      xv = ext_bit_valid;
      xb = ext_bit;
    end
    if (cyc == 20000) begin
      bad_count++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] rd_data);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h00_0000, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_data = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr
  // ***************************
  // Scenarios
  // ***************************
  task automatic s_wake(input logic [1:0] crit, input logic [7:0] cnt, input logic [31:0] pat,
                        input int n, input int exp);
    int b;
    wr(WFS_IDX_WAKE_CTRL_A, {6'h00, crit});
    wr(WFS_IDX_WAKE_PAT_LO_A, pat[7:0]);
    wr(WFS_IDX_WAKE_PAT_HI_A, pat[15:8]);
    wr(WFS_IDX_WAKE_CNT_A, cnt);
    b = wk_n;
    u_wfs_chip_src.set_sync(1'b1);
    u_wfs_chip_src.send(pat, n, 3);
    repeat (4) @(posedge hclk);
    chk(wk_n - b, exp);
    u_wfs_chip_src.set_sync(1'b0);
    repeat (2) @(posedge hclk);
  endtask : s_wake
  task automatic s_frame(input logic sel, input logic [1:0] mode, input logic [7:0] la,
                         input logic [7:0] lb, input logic [31:0] rf, input logic [31:0] pat,
                         input int n, input logic ex, input logic eb);
    logic [7:0] o;
    int b;
    o = sel ? WFS_IDX_SET_B_OFS : 8'h00;
    wr(WFS_IDX_GLOBAL_CTRL, {7'h00, sel});
    wr(WFS_IDX_MARK_MODE + o, {6'h00, mode});
    wr(WFS_IDX_CORR_A_LEN + o, la);
    wr(WFS_IDX_CORR_B_LEN + o, lb);
    wr(WFS_IDX_CORR_A_LO + o, rf[7:0]);
    wr(WFS_IDX_CORR_A_HI + o, rf[15:8]);
    wr(WFS_IDX_CORR_B_LO + o, rf[23:16]);
    wr(WFS_IDX_CORR_B_HI + o, rf[31:24]);
    b = fs_n;
    u_wfs_chip_src.set_sync(1'b1);
    repeat (2) @(posedge hclk);
    chk({31'h0000_0000, searching}, 32'h0000_0001);
    u_wfs_chip_src.send(pat, n, 1);
    repeat (4) @(posedge hclk);
    chk(fs_n - b, 1);
    chk({31'h0000_0000, xv}, {31'h0000_0000, ex});
    if (ex) chk({31'h0000_0000, xb}, {31'h0000_0000, eb});
    bus(1'b0, WFS_IDX_STATUS, 8'h00, r);
    chk(r & 32'h0000_0007, {29'h0000_0000, WFS_ST_FRAMED});
    u_wfs_chip_src.set_sync(1'b0);
    repeat (2) @(posedge hclk);
  endtask : s_frame
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, WFS_IDX_STATUS, 8'h00, r);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    bus(1'b0, 8'hf0, 8'h00, r);
    chk(r, 32'h0000_0000);
    wr(WFS_IDX_GLOBAL_CTRL, 8'h02);
    s_wake(WFS_CRIT_PATTERN, 8'h11, 32'h0001_a5c3, 17, 1);
    s_wake(WFS_CRIT_PATTERN, 8'h00, 32'h0000_a5c3, 16, 0);
    s_wake(WFS_CRIT_PATTERN, 8'h11, 32'h000f_a5c3, 20, 0);
    s_wake(WFS_CRIT_RANDOM, 8'h00, 32'h0000_0000, 0, 1);
    s_wake(WFS_CRIT_RANDOM, 8'h08, 32'h0000_00c7, 8, 0);
    s_wake(WFS_CRIT_EQUAL, 8'h08, 32'h0000_00aa, 8, 1);
    s_wake(WFS_CRIT_EQUAL, 8'h08, 32'h0000_00a6, 8, 0);
    // Sixteen chips without sync overrun the search timeout
    u_wfs_chip_src.send(32'h0000_5555, 16, 3);
    s_wake(WFS_CRIT_SYNC, 8'h00, 32'h0000_0000, 0, 0);
    s_wake(WFS_CRIT_SYNC, 8'h00, 32'h0000_0000, 0, 1);
    s_frame(1'b0, WFS_MODE_SINGLE, 8'h10, 8'h10, 32'h0ff0_5a3c, 32'h0ff0_5a3c, 32, 0, 0);
    s_frame(1'b0, WFS_MODE_PARALLEL, 8'h08, 8'h06, 32'h0027_00b4, 32'h0000_0027, 10, 0, 0);
    s_frame(1'b0, WFS_MODE_EXTENDED, 8'h08, 8'h06, 32'h0027_00b4, 32'h0000_0027, 10, 1, 1);
    s_frame(1'b0, WFS_MODE_EXTENDED, 8'h08, 8'h06, 32'h0027_00b4, 32'h0000_00b4, 8, 1, 0);
    s_frame(1'b1, WFS_MODE_SINGLE, 8'h04, 8'h00, 32'h0000_0009, 32'h0000_0009, 4, 0, 0);
    wr(WFS_IDX_MARK_GAP_A, 8'h02);
    s_frame(1'b0, WFS_MODE_GAP, 8'h04, 8'h04, 32'h0003_000c, 32'h0000_0653, 11, 0, 0);
    end_of_test;
  end
endmodule : wfs_top_bench
